// ### shared/drs_pkg.sv
// constants and types shared by the display reset sequencer
package drs_pkg;

	// ==========================================================
	// timebase
	localparam int CLK_MHZ = 100;

	// ==========================================================
	// reset pin spike filter
	localparam int REJECT_US = 5;
	localparam int ACCEPT_US = 9;
	localparam int REJECT_CYC = REJECT_US * CLK_MHZ;
	localparam int ACCEPT_CYC = ACCEPT_US * CLK_MHZ;
	// trip point inside the indeterminate band
	localparam int TRIP_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;
	// a release must stay high as long as a rejected spike may last
	localparam int RELEASE_CYC = REJECT_CYC;
	localparam int FILT_CNT_W = 16;

	// ==========================================================
	// reset cancel interval
	localparam int CANCEL_SLEEP_MS = 5;
	localparam int CANCEL_AWAKE_MS = 120;
	localparam int CANCEL_SLEEP_CYC = CANCEL_SLEEP_MS * 1000 * CLK_MHZ;
	localparam int CANCEL_AWAKE_CYC = CANCEL_AWAKE_MS * 1000 * CLK_MHZ;
	localparam int CANCEL_CNT_W = 24;

	// ==========================================================
	// non-volatile settings image
	localparam int NVM_WORDS = 4;
	localparam int NVM_ADDR_W = 2;
	localparam int ID_WORDS = 3;
	localparam int COMMON_VOLTAGE_SETTING_IDX = 3;
	localparam logic [7:0] SHADOW_RESET = 8'h00;

	// ==========================================================
	// sequencer states, gray from DRS_RUN to DRS_DEFAULT on the awake path
	typedef enum logic [2:0] {
		DRS_RUN = 3'b000,
		DRS_HELD = 3'b001,
		DRS_RELOAD = 3'b011,
		DRS_BLANK = 3'b010,
		DRS_DEFAULT = 3'b110
	} drs_state_t;

endpackage

// ### shared/drs_rst_if.sv
// filtered reset events passed from the spike filter to the sequencer
`timescale 1ns/1ns
interface drs_rst_if;
	logic resetActive;
	logic assertPulse;
	logic releasePulse;
	modport filt (output resetActive, output assertPulse, output releasePulse);
	modport seq (input resetActive, input assertPulse, input releasePulse);
endinterface

// ### verilog/drs_spike_filter.sv
// spike filter on the host reset pin
`timescale 1ns/1ns
module drs_spike_filter #(
	parameter int TRIP = drs_pkg::TRIP_CYC,
	parameter int RELEASE = drs_pkg::RELEASE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hwResetN,
	drs_rst_if.filt rif
);

	localparam int FW = drs_pkg::FILT_CNT_W;

	typedef struct packed {
		logic active;
		logic [drs_pkg::FILT_CNT_W-1:0] cnt;
		logic assertP;
		logic releaseP;
	} drs_filt_t;

	drs_filt_t st;
	drs_filt_t next_st;

	// ==========================================================
	// elaboration checks
	if (TRIP < drs_pkg::REJECT_CYC || TRIP > drs_pkg::ACCEPT_CYC)
		$error("trip point outside the filter band");
	if (RELEASE < 2 || RELEASE >= (1 << drs_pkg::FILT_CNT_W))
		$error("release count out of range");

	// ==========================================================
	// filter
	always_comb begin
		next_st = st;
		next_st.assertP = 1'b0;
		next_st.releaseP = 1'b0;
		if (!st.active) begin
			if (!hwResetN) begin
				next_st.cnt = st.cnt + 1'b1;
				// short lows never reach the trip count
				if (st.cnt == FW'(TRIP - 1)) begin // RQ1 RQ2
					next_st.active = 1'b1;
					next_st.assertP = 1'b1;
					next_st.cnt = '0;
				end
			end else begin
				next_st.cnt = '0;
			end
		end else begin
			// high glitches inside a held reset are filtered too
			if (hwResetN) begin // RQ3
				next_st.cnt = st.cnt + 1'b1;
				if (st.cnt == FW'(RELEASE - 1)) begin
					next_st.active = 1'b0;
					next_st.releaseP = 1'b1;
					next_st.cnt = '0;
				end
			end else begin
				next_st.cnt = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rif.resetActive = st.active;
	assign rif.assertPulse = st.assertP;
	assign rif.releasePulse = st.releaseP;

	// ==========================================================
	// checks
	logic [drs_pkg::FILT_CNT_W-1:0] lowRun;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			lowRun <= '0;
		end else if (hwResetN) begin
			lowRun <= '0;
		end else if (lowRun != '1) begin
			lowRun <= lowRun + 1'b1;
		end
	end

	// a high run that reaches the release count is a real release
	sequence highGlitch;
		rif.resetActive && hwResetN && st.cnt < FW'(RELEASE - 1)
			##1 !hwResetN;
	endsequence

	short_low_reject_a: assert property ( // RQ1
		@(posedge clk) disable iff (!resetn)
		$rose(rif.assertPulse) |-> $past(lowRun) >= drs_pkg::REJECT_CYC - 1)
		else $error("reset taken on a short low pulse");
	long_low_accept_a: assert property ( // RQ1
		@(posedge clk) disable iff (!resetn)
		lowRun == FW'(drs_pkg::ACCEPT_CYC) |-> rif.resetActive)
		else $error("long low pulse not taken as reset");
	glitch_hold_a: assert property ( // RQ3
		@(posedge clk) disable iff (!resetn)
		highGlitch |-> ##1 rif.resetActive && !rif.releasePulse)
		else $error("high glitch released the reset");

endmodule

// ### verilog/drs_reset_sequencer.sv
// hardware reset sequencer of the display controller
//
// Function
// RQ1 - Reset pin lows under 5 us are ignored, lows over 9 us always reset.
// RQ2 - Lows between 5 us and 9 us may or may not reset the device.
// RQ3 - High glitches inside a held reset are filtered, not a release.
// RQ4 - Each release reloads id bytes and common voltage from storage.
// RQ5 - Display is blank in reset, with up to 120 ms blanking if awake.
// RQ6 - After blanking all state returns to its hardware reset defaults.
// RQ7 - Reset cancel ends within 5 ms from sleep and within 120 ms from awake.
// RQ8 - The host sends no command until 5 ms after releasing reset.
// RQ9 - The host sends no wake command until 120 ms after releasing reset.
// RQ10 - Command bytes arriving while the reset sequence runs are discarded.
`timescale 1ns/1ns
module drs_reset_sequencer #(
	parameter int CANCEL_SLEEP = drs_pkg::CANCEL_SLEEP_CYC,
	parameter int CANCEL_AWAKE = drs_pkg::CANCEL_AWAKE_CYC,
	parameter int TRIP = drs_pkg::TRIP_CYC,
	parameter int RELEASE = drs_pkg::RELEASE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic hwResetN,
	input wire logic awake,
	output logic nvmRead,
	output logic [drs_pkg::NVM_ADDR_W-1:0] nvmAddr,
	input wire logic [7:0] nvmData,
	output logic [8*drs_pkg::ID_WORDS-1:0] idBytes,
	output logic [7:0] commonVoltageSetting,
	output logic displayBlank,
	output logic resetBusy,
	output logic defaultsLoad,
	input wire logic cmdValid,
	input wire logic [7:0] cmdByte,
	output logic cmdOutValid,
	output logic [7:0] cmdOutByte,
	output logic cmdDropped
);

	localparam int CW = drs_pkg::CANCEL_CNT_W;
	localparam int AW = drs_pkg::NVM_ADDR_W;

	typedef struct packed {
		drs_pkg::drs_state_t state;
		logic wasAwake;
		logic [CW-1:0] cnt;
		logic [AW-1:0] idx;
		logic reading;
		logic [drs_pkg::NVM_WORDS-1:0][7:0] shadow;
		logic blank;
		logic dflt;
		logic outValid;
		logic [7:0] outByte;
		logic dropped;
		logic rd;
		logic busy;
	} drs_seq_t;

	drs_seq_t st;
	drs_seq_t next_st;

	// ==========================================================
	// elaboration checks
	if (CANCEL_AWAKE >= (1 << CW) || CANCEL_AWAKE <= CANCEL_SLEEP)
		$error("cancel counts out of range");
	if (CANCEL_SLEEP <= 4 * drs_pkg::NVM_WORDS)
		$error("sleep cancel too short for the reload");
	if (drs_pkg::NVM_WORDS != (1 << AW) || drs_pkg::COMMON_VOLTAGE_SETTING_IDX < drs_pkg::ID_WORDS)
		$error("settings image layout inconsistent");

	// ==========================================================
	// filtered reset pin
	drs_rst_if rif ();

	drs_spike_filter #(
		.TRIP(TRIP),
		.RELEASE(RELEASE)
	) u_filter (
		.clk(clk),
		.resetn(resetn),
		.hwResetN(hwResetN),
		.rif(rif)
	);

	function automatic logic seqBusy(input drs_pkg::drs_state_t s);
		seqBusy = (s != drs_pkg::DRS_RUN);
	endfunction

	// ==========================================================
	// sequencer
	always_comb begin
		next_st = st;
		next_st.dflt = 1'b0;
		next_st.outValid = 1'b0;
		next_st.dropped = 1'b0;
		if (st.cnt != '1) begin
			next_st.cnt = st.cnt + 1'b1;
		end
		unique case (st.state)
			drs_pkg::DRS_RUN: begin
				if (rif.assertPulse) begin
					next_st.state = drs_pkg::DRS_HELD;
					next_st.wasAwake = awake;
				end
			end
			drs_pkg::DRS_HELD: begin
				if (rif.releasePulse) begin
					next_st.state = drs_pkg::DRS_RELOAD; // RQ4
					next_st.cnt = '0;
					next_st.idx = '0;
					next_st.reading = 1'b0;
				end
			end
			drs_pkg::DRS_RELOAD: begin
				// read one word, capture it the cycle after
				next_st.reading = !st.reading;
				if (st.reading) begin
					next_st.shadow[st.idx] = nvmData; // RQ4
					next_st.idx = st.idx + 1'b1;
					if (st.idx == AW'(drs_pkg::NVM_WORDS - 1)) begin
						next_st.state = st.wasAwake ? drs_pkg::DRS_BLANK
							: drs_pkg::DRS_DEFAULT;
					end
				end
			end
			drs_pkg::DRS_BLANK: begin
				// blanking ends one cycle ahead so defaults land in time
				if (st.cnt >= CW'(CANCEL_AWAKE - 2)) begin // RQ5 RQ7
					next_st.state = drs_pkg::DRS_DEFAULT;
				end
			end
			drs_pkg::DRS_DEFAULT: begin
				next_st.state = drs_pkg::DRS_RUN; // RQ6
				next_st.dflt = 1'b1;
				next_st.wasAwake = 1'b0;
			end
			default: begin
				next_st.state = drs_pkg::DRS_HELD;
			end
		endcase
		// a new reset aborts any stage of the sequence
		if (rif.assertPulse && seqBusy(st.state)) begin
			next_st.state = drs_pkg::DRS_HELD;
			// a sequence cut short must not announce defaults
			next_st.dflt = 1'b0;
		end
		// registered so the pins come straight from flops
		next_st.rd = (next_st.state == drs_pkg::DRS_RELOAD)
			&& !next_st.reading;
		next_st.busy = seqBusy(next_st.state);
		// outside the sequence the display is blanked only while awake is low
		next_st.blank = seqBusy(next_st.state) || !awake; // RQ5
		// commands only reach the core once the sequence is done
		if (cmdValid) begin
			if (seqBusy(st.state) || rif.assertPulse) begin
				next_st.dropped = 1'b1; // RQ10
			end else begin
				next_st.outValid = 1'b1;
				next_st.outByte = cmdByte;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '{
				state: drs_pkg::DRS_RUN,
				wasAwake: 1'b0,
				cnt: '0,
				idx: '0,
				reading: 1'b0,
				shadow: {drs_pkg::NVM_WORDS{drs_pkg::SHADOW_RESET}},
				blank: 1'b1,
				dflt: 1'b0,
				outValid: 1'b0,
				outByte: 8'h00,
				dropped: 1'b0,
				rd: 1'b0,
				busy: 1'b0
			};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign nvmRead = st.rd;
	assign nvmAddr = st.idx;
	assign idBytes = st.shadow[drs_pkg::ID_WORDS-1:0];
	assign commonVoltageSetting = st.shadow[drs_pkg::COMMON_VOLTAGE_SETTING_IDX];
	assign displayBlank = st.blank;
	assign resetBusy = st.busy;
	assign defaultsLoad = st.dflt;
	assign cmdOutValid = st.outValid;
	assign cmdOutByte = st.outByte;
	assign cmdDropped = st.dropped;

	// ==========================================================
	// checks
	sequence releaseSeen;
		rif.releasePulse && st.state == drs_pkg::DRS_HELD;
	endsequence

	sequence reloadStart;
		st.state == drs_pkg::DRS_RELOAD && st.idx == '0 && nvmRead;
	endsequence

	reload_follows_a: assert property ( // RQ4
		@(posedge clk) disable iff (!resetn)
		releaseSeen |-> ##1 reloadStart)
		else $error("release not followed by settings reload");
	common_voltage_setting_capture_a: assert property ( // RQ4
		@(posedge clk) disable iff (!resetn)
		st.state == drs_pkg::DRS_RELOAD && st.reading
			&& st.idx == AW'(drs_pkg::COMMON_VOLTAGE_SETTING_IDX) && !rif.assertPulse
			|=> commonVoltageSetting == $past(nvmData))
		else $error("common voltage setting not loaded");
	blank_busy_a: assert property ( // RQ5
		@(posedge clk) disable iff (!resetn)
		resetBusy |-> displayBlank)
		else $error("display not blank during reset");
	defaults_end_a: assert property ( // RQ6
		@(posedge clk) disable iff (!resetn)
		defaultsLoad |-> !resetBusy
			&& $past(st.state) == drs_pkg::DRS_DEFAULT)
		else $error("defaults not applied at end of sequence");
	sleep_bound_a: assert property ( // RQ7
		@(posedge clk) disable iff (!resetn)
		st.state == drs_pkg::DRS_DEFAULT && !st.wasAwake
			|-> st.cnt < CW'(CANCEL_SLEEP))
		else $error("sleep reset cancel too long");
	awake_bound_a: assert property ( // RQ7
		@(posedge clk) disable iff (!resetn)
		st.state == drs_pkg::DRS_BLANK |-> st.cnt < CW'(CANCEL_AWAKE))
		else $error("awake reset cancel too long");
	cmd_drop_a: assert property ( // RQ10
		@(posedge clk) disable iff (!resetn)
		cmdValid && resetBusy |=> cmdDropped && !cmdOutValid)
		else $error("command passed during reset sequence");

endmodule

// ### dv/drs_nvm_model.sv
// storage model answering the settings reads made after a reset release
`timescale 1ns/1ns
module drs_nvm_model (
	input wire logic clk,
	input wire logic nvmRead,
	input wire logic [drs_pkg::NVM_ADDR_W-1:0] nvmAddr,
	input wire logic [7:0] salt,
	output logic [7:0] nvmData
);
	initial begin
		nvmData = 8'h5A;
	end
	// ==========================================================
	// read port
	always @(posedge clk) begin
		if (nvmRead) begin
			// word k of the image is salt plus k times 11h
			nvmData <= salt + 8'h11 * {6'h00, nvmAddr};
		end else begin
			// outside a read the bus toggles so stale data never matches
			nvmData <= ~nvmData;
		end
	end
endmodule

// ### dv/test_display_hw_reset_sequencer.sv
// self-checking bench for the display reset sequencer
`timescale 1ns/1ns
module test_display_hw_reset_sequencer;
	localparam int SLEEP = 40;
	localparam int AWAKE = 1000;
	localparam int REL = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hwResetN = 1'b1;
	logic awake = 1'b0;
	logic cmdValid = 1'b0;
	logic [7:0] cmdByte = 8'h00;
	logic [7:0] salt = 8'h00;
	logic [7:0] nvmData, commonVoltageSetting, cmdOutByte;
	logic nvmRead, displayBlank, resetBusy, defaultsLoad;
	logic cmdOutValid, cmdDropped;
	logic [drs_pkg::NVM_ADDR_W-1:0] nvmAddr;
	logic [8*drs_pkg::ID_WORDS-1:0] idBytes;
	int errTotal = 0;
	int numChecks = 0;

	always #5 clk = ~clk;

	drs_reset_sequencer #(.CANCEL_SLEEP(SLEEP), .CANCEL_AWAKE(AWAKE),
		.TRIP(700), .RELEASE(REL)) dut (.clk(clk), .resetn(resetn),
		.hwResetN(hwResetN), .awake(awake), .nvmRead(nvmRead),
		.nvmAddr(nvmAddr), .nvmData(nvmData), .idBytes(idBytes),
		.commonVoltageSetting(commonVoltageSetting),
		.displayBlank(displayBlank), .resetBusy(resetBusy),
		.defaultsLoad(defaultsLoad), .cmdValid(cmdValid),
		.cmdByte(cmdByte), .cmdOutValid(cmdOutValid),
		.cmdOutByte(cmdOutByte), .cmdDropped(cmdDropped));

	drs_nvm_model nvm (.clk(clk), .nvmRead(nvmRead), .nvmAddr(nvmAddr),
		.salt(salt), .nvmData(nvmData));

	// ==========================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] exp, got);
		numChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic testDone;
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// low pulse of n cycles, optional short high glitch from cycle g
	task automatic lowPulse(input int n, input int g, output logic busy,
		output logic act);
		busy = 1'b0;
		act = 1'b0;
		for (int i = 0; i < n; i++) begin
			hwResetN = g > 0 && i >= g && i < g + REL - 3;
			@(negedge clk);
			busy |= resetBusy;
			act |= defaultsLoad | nvmRead;
		end
	endtask

	task automatic sendCmd(input logic [7:0] b, input logic fwd);
		cmdValid = 1'b1;
		cmdByte = b;
		@(negedge clk);
		cmdValid = 1'b0;
		chk("cmdOutValid", fwd, cmdOutValid);
		chk("cmdDropped", !fwd, cmdDropped);
		if (fwd) begin
			chk("cmdOutByte", b, cmdOutByte);
		end
	endtask

	task automatic waitDone(input int lim, output int n);
		n = 0;
		while (defaultsLoad !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
			if (resetBusy === 1'b1) begin
				chk("displayBlank", 1, displayBlank);
			end
		end
		if (defaultsLoad !== 1'b1) begin
			errTotal++;
			testDone();
		end
	endtask

	// ==========================================================
	// scenarios
	task automatic spikeCase;
		logic busy, act;
		lowPulse(499, 0, busy, act);
		hwResetN = 1'b1;
		chk("spikeBusy", 0, busy);
		chk("spikeReload", 0, act);
		sendCmd(8'h3C, 1'b1);
		$display("spike case done");
	endtask

	task automatic resetCase(input logic awk, input logic [7:0] s);
		logic busy, act;
		int n;
		awake = awk;
		salt = s;
		lowPulse(1000, awk ? 800 : 0, busy, act);
		chk("resetBusy", 1, busy);
		chk("earlyRelease", 0, act);
		sendCmd(8'hA5, 1'b0);
		hwResetN = 1'b1;
		waitDone(AWAKE + REL + 20, n);
		if (awk) begin
			chk("awakeTime", 1, n >= AWAKE && n <= AWAKE + REL + 2);
		end else begin
			chk("sleepTime", 1, n <= SLEEP + REL);
		end
		chk("idBytes", {s + 8'h22, s + 8'h11, s}, idBytes);
		chk("commonVoltage", s + 8'h33, commonVoltageSetting);
		@(negedge clk);
		chk("busyAfter", 0, resetBusy);
		chk("blankAfter", !awk, displayBlank);
		// host holds off commands for the sleep cancel interval after the sequence ends
		repeat (SLEEP) @(negedge clk);
		sendCmd(s, 1'b1);
		$display("reset case awake=%0d done", awk);
	endtask

	// a second trip while blanking restarts the whole sequence
	task automatic abortCase;
		logic busy, act;
		int n;
		awake = 1'b1;
		salt = 8'hC7;
		lowPulse(710, 0, busy, act);
		hwResetN = 1'b1;
		repeat (REL + 30) @(negedge clk);
		chk("midBusy", 1, resetBusy);
		chk("midId", {salt + 8'h22, salt + 8'h11, salt}, idBytes);
		sendCmd(8'h11, 1'b0);
		salt = 8'h2E;
		lowPulse(710, 0, busy, act);
		chk("abortBusy", 1, busy);
		chk("abortQuiet", 0, act);
		hwResetN = 1'b1;
		waitDone(AWAKE + REL + 20, n);
		chk("abortTime", 1, n >= AWAKE && n <= AWAKE + REL + 2);
		chk("abortId", {salt + 8'h22, salt + 8'h11, salt}, idBytes);
		chk("abortVcom", salt + 8'h33, commonVoltageSetting);
		$display("abort case done");
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (3) @(negedge clk);
		chk("idAtReset", 0, idBytes);
		chk("busyAtReset", 0, resetBusy);
		resetn = 1'b1;
		@(negedge clk);
		spikeCase();
		resetCase(1'b0, 8'h40);
		resetCase(1'b1, 8'h93);
		abortCase();
		testDone();
	end
endmodule
